// >>> shared/asl_defines.vh
`ifndef ASL_DEFINES_VH
`define ASL_DEFINES_VH

// register offsets
`define ASL_CFG_A_ADDR      8'h2A
`define ASL_CFG_B_ADDR      8'h2B

// reset values
`define ASL_CFG_A_RESET     8'h03
`define ASL_CFG_B_RESET     8'h00

// config a fields
`define ASL_GAIN_HI         7
`define ASL_GAIN_LO         5
`define ASL_SYNC_MODE_BIT   4
`define ASL_AUTO_LEVEL_BIT  3
`define ASL_FOLLOW_BIT      2
`define ASL_SRC_HI          1
`define ASL_SRC_LO          0
`define ASL_SRC_SINGLE      2'h0
`define ASL_SRC_NONE        2'h3

// config b fields
`define ASL_AVG_BIT         4
`define ASL_MAP_HI          3
`define ASL_MAP_LO          2
`define ASL_SPEED_HI        1
`define ASL_SPEED_LO        0
`define ASL_CFG_B_MASK      8'h1F

// mapping codes
`define ASL_MAP_PARTLY      2'h0
`define ASL_MAP_NONOVL      2'h1
`define ASL_MAP_OVL         2'h2
`define ASL_RANGE_HIGH      2'h0

// sample rate and filter timing
`define ASL_SAMPLE_HZ       16000
`define ASL_DC_CORNER_HZ    400
`define ASL_DC_SHIFT        4'h3
`define ASL_LP1_SHIFT_WIDE  4'h3
`define ASL_LP1_SHIFT_NARR  4'h4
`define ASL_LP2_SHIFT_WIDE  4'h1
`define ASL_LP2_SHIFT_NARR  4'h2
`define ASL_SLOW_AMP_MHZ    3800
`define ASL_SLOW_FREQ_MHZ   7600
`define ASL_DECAY_BASE      4'h4

// automatic level
`define ASL_AGC_WINDOW      8'hFF
`define ASL_AGC_HIGH        15'h6000
`define ASL_AGC_LOW         15'h1000

// amplitude mapping thresholds
`define ASL_THR_THIRD       8'h55
`define ASL_THR_2THIRD      8'hAA
`define ASL_THR_QUART       8'h40
`define ASL_THR_HALF        8'h80
`define ASL_THR_3QUART      8'hC0

`endif

// >>> verilog/asl_audio_follow.v
// Summary of operation
// - manual gain code 0..7 gives 0 to 21 dB in 3 dB steps, zero default.
// - mode bit clear selects amplitude follow, set selects frequency-band follow.
// - auto-level bit set adapts gain; clear uses manual gain code.
// - follow-enable bit turns sync on, default off; adaptive gain starts at manual code.
// - source code 00 selects single-ended input, 11 no input (default); 01/10 unused.
// - averaging bit has no effect while audio follow is running.
// - response code 00 fastest, 01 fast, 10 medium, 11 slow.
// - slowest setting limits modulation to 3.8 Hz amplitude, 7.6 Hz frequency mode.
// - frequency mode mapping 00 wide range to 8 kHz, 01 narrow to 4 kHz.
// - frequency mode drives red from low, blue from mid, green from high band.
// - amplitude mapping 01 non-overlapping, 00 partly overlapping, 10 overlapping.
// - dc removed by high-pass stage with corner at 400 Hz.
// - amplitude mode uses peak detection; frequency mode a three-band filter.
`timescale 1ns/1ps
`default_nettype none
`include "asl_defines.vh"

module asl_audio_follow (
  input  wire        clk_sys,       // 125 MHz system clock
  input  wire        rst_n,         // async reset, active low
  input  wire [7:0]  reg_addr,      // register offset
  input  wire [7:0]  reg_wdata,     // write data
  input  wire        reg_wr,        // write strobe
  input  wire        reg_rd,        // read strobe
  output reg  [7:0]  reg_rdata,     // read data, valid cycle after reg_rd
  input  wire [11:0] audio_sample,  // signed converter sample
  input  wire        audio_valid,   // one-cycle sample strobe
  output reg  [7:0]  led_red,       // red brightness
  output reg  [7:0]  led_green,     // green brightness
  output reg  [7:0]  led_blue,      // blue brightness
  output reg  [2:0]  gain_now,      // gain code in use
  output reg         follow_active  // sync running on a real source
);

  reg  [7:0] audio_follow_config_a;
  reg  [7:0] audio_follow_config_b;

  wire [2:0] gain_code     = audio_follow_config_a[`ASL_GAIN_HI:`ASL_GAIN_LO];
  wire       freq_mode     = audio_follow_config_a[`ASL_SYNC_MODE_BIT];
  wire       auto_level_on = audio_follow_config_a[`ASL_AUTO_LEVEL_BIT];
  wire       follow_on     = audio_follow_config_a[`ASL_FOLLOW_BIT];
  wire [1:0] src_sel       = audio_follow_config_a[`ASL_SRC_HI:`ASL_SRC_LO];
  wire       averaging_on  = audio_follow_config_b[`ASL_AVG_BIT];
  wire [1:0] map_code      = audio_follow_config_b[`ASL_MAP_HI:`ASL_MAP_LO];
  wire [1:0] speed_code    = audio_follow_config_b[`ASL_SPEED_HI:`ASL_SPEED_LO];

  // averaging_on is stored for readback only
  wire       run = follow_on && (src_sel == `ASL_SRC_SINGLE);

  // gain in 1/16 steps, 3 dB apart
  function [7:0] gain_q4;
    input [2:0] code;
    begin
      case (code)
        3'h0:    gain_q4 = 8'h10;
        3'h1:    gain_q4 = 8'h17;
        3'h2:    gain_q4 = 8'h20;
        3'h3:    gain_q4 = 8'h2D;
        3'h4:    gain_q4 = 8'h40;
        3'h5:    gain_q4 = 8'h5A;
        3'h6:    gain_q4 = 8'h80;
        default: gain_q4 = 8'hB3;
      endcase
    end
  endfunction

  // envelope decay shift; frequency mode decays twice as fast
  function [3:0] decay_shift;
    input [1:0] speed;
    input       fmode;
    begin
      decay_shift = `ASL_DECAY_BASE + {1'b0, speed, 1'b0} - {3'h0, fmode};
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register access
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      audio_follow_config_a <= `ASL_CFG_A_RESET;
      audio_follow_config_b <= `ASL_CFG_B_RESET;
      reg_rdata             <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `ASL_CFG_A_ADDR)
        audio_follow_config_a <= reg_wdata;
      if (reg_wr && reg_addr == `ASL_CFG_B_ADDR)
        audio_follow_config_b <= reg_wdata & `ASL_CFG_B_MASK;
      if (reg_rd) begin
        case (reg_addr)
          `ASL_CFG_A_ADDR: reg_rdata <= audio_follow_config_a;
          `ASL_CFG_B_ADDR: reg_rdata <= audio_follow_config_b;
          default:         reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // dc remover and gain
  wire signed [15:0] x16   = {{4{audio_sample[11]}}, audio_sample};
  reg  signed [23:0] dc_est;
  wire signed [15:0] hp    = x16 - dc_est[23:8];
  wire signed [23:0] dc_step = $signed({hp, 8'h00}) >>> `ASL_DC_SHIFT;
  reg  signed [15:0] hp_r;
  wire signed [24:0] prod  = hp_r * $signed({1'b0, gain_q4(gain_now)});
  wire signed [20:0] prod4 = prod[24:4];
  wire signed [15:0] gained = (prod4 > 21'sh007FFF) ? 16'sh7FFF :
                              (prod4 < -21'sh008000) ? 16'sh8000 : prod4[15:0];
  reg                stage2;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dc_est <= 24'h000000;
      hp_r   <= 16'h0000;
      stage2 <= 1'b0;
    end else begin
      stage2 <= audio_valid && run;
      if (!run) begin
        dc_est <= 24'h000000;
        hp_r   <= 16'h0000;
      end else if (audio_valid) begin
        dc_est <= dc_est + dc_step;
        hp_r   <= hp;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // three-band split
  reg  signed [23:0] lp1;
  reg  signed [23:0] lp2;
  wire               wide   = (map_code == `ASL_RANGE_HIGH);
  wire [3:0]         sh1    = wide ? `ASL_LP1_SHIFT_WIDE : `ASL_LP1_SHIFT_NARR;
  wire [3:0]         sh2    = wide ? `ASL_LP2_SHIFT_WIDE : `ASL_LP2_SHIFT_NARR;
  wire signed [15:0] d1     = gained - lp1[23:8];
  wire signed [15:0] d2     = gained - lp2[23:8];
  wire signed [15:0] band_lo  = lp1[23:8];
  wire signed [15:0] band_mid = lp2[23:8] - lp1[23:8];
  wire signed [15:0] band_hi  = d2;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lp1 <= 24'h000000;
      lp2 <= 24'h000000;
    end else if (!run) begin
      lp1 <= 24'h000000;
      lp2 <= 24'h000000;
    end else if (stage2) begin
      lp1 <= lp1 + ($signed({d1, 8'h00}) >>> sh1);
      lp2 <= lp2 + ($signed({d2, 8'h00}) >>> sh2);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // peak envelopes with speed-dependent decay
  wire [3:0]  dshift = decay_shift(speed_code, freq_mode);
  wire [47:0] env_in;
  wire [44:0] env_all;
  assign env_in = freq_mode ? {band_hi, band_mid, band_lo} : {gained, gained, gained};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_env
      wire signed [15:0] sv  = env_in[gi*16 +: 16];
      wire [15:0]        mag16 = sv[15] ? (16'h0000 - sv) : sv;
      wire [14:0]        mag = mag16[15] ? 15'h7FFF : mag16[14:0];
      reg  [14:0]        env;
      wire [14:0]        decayed = env - (env >> dshift);
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          env <= 15'h0000;
        else if (!run)
          env <= 15'h0000;
        else if (stage2)
          env <= (mag > decayed) ? mag : decayed;
      end
      assign env_all[gi*15 +: 15] = env;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // automatic level
  reg  [7:0] agc_cnt;
  reg        auto_prev;
  reg        agc_hi_seen;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain_now    <= 3'h0;
      agc_cnt     <= 8'h00;
      auto_prev   <= 1'b0;
      agc_hi_seen <= 1'b0;
    end else begin
      auto_prev <= auto_level_on && run;
      if (!(auto_level_on && run)) begin
        gain_now    <= gain_code;
        agc_cnt     <= 8'h00;
        agc_hi_seen <= 1'b0;
      end else if (!auto_prev) begin
        gain_now    <= gain_code;
        agc_cnt     <= 8'h00;
        agc_hi_seen <= 1'b0;
      end else if (stage2) begin
        if (env_all[14:0] > `ASL_AGC_LOW)
          agc_hi_seen <= 1'b1;
        if (env_all[14:0] > `ASL_AGC_HIGH && gain_now != 3'h0) begin
          gain_now    <= gain_now - 3'h1;
          agc_cnt     <= 8'h00;
          agc_hi_seen <= 1'b0;
        end else if (agc_cnt == `ASL_AGC_WINDOW) begin
          agc_cnt     <= 8'h00;
          agc_hi_seen <= 1'b0;
          if (!agc_hi_seen && env_all[14:0] <= `ASL_AGC_LOW && gain_now != 3'h7)
            gain_now <= gain_now + 3'h1;
        end else begin
          agc_cnt <= agc_cnt + 8'h01;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // colour mapping
  wire [7:0] lvl = env_all[14:7];
  reg  [7:0] next_red;
  reg  [7:0] next_green;
  reg  [7:0] next_blue;

  always @* begin
    next_red   = 8'h00;
    next_green = 8'h00;
    next_blue  = 8'h00;
    if (freq_mode) begin
      next_red   = env_all[14:7];
      next_blue  = env_all[29:22];
      next_green = env_all[44:37];
    end else begin
      case (map_code)
        `ASL_MAP_NONOVL: begin
          next_red   = (lvl < `ASL_THR_THIRD) ? lvl : 8'h00;
          next_green = (lvl >= `ASL_THR_THIRD && lvl < `ASL_THR_2THIRD) ? lvl : 8'h00;
          next_blue  = (lvl >= `ASL_THR_2THIRD) ? lvl : 8'h00;
        end
        `ASL_MAP_OVL: begin
          next_red   = lvl;
          next_green = (lvl >= `ASL_THR_QUART) ? lvl : 8'h00;
          next_blue  = (lvl >= `ASL_THR_HALF) ? lvl : 8'h00;
        end
        default: begin
          next_red   = (lvl < `ASL_THR_HALF) ? lvl : 8'h00;
          next_green = (lvl >= `ASL_THR_QUART && lvl < `ASL_THR_3QUART) ? lvl : 8'h00;
          next_blue  = (lvl >= `ASL_THR_HALF) ? lvl : 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_red       <= 8'h00;
      led_green     <= 8'h00;
      led_blue      <= 8'h00;
      follow_active <= 1'b0;
    end else begin
      follow_active <= run;
      led_red       <= run ? next_red : 8'h00;
      led_green     <= run ? next_green : 8'h00;
      led_blue      <= run ? next_blue : 8'h00;
    end
  end

endmodule // asl_audio_follow
`default_nettype wire

// >>> dv/asl_audio_source.sv
`timescale 1ns/1ps
`default_nettype none
module asl_audio_source (
  input  wire logic        clk_sys,      // clock
  input  wire logic        rst_n,        // reset
  input  wire logic        en,           // playing
  input  wire logic [10:0] amp,          // peak level
  input  wire logic [5:0]  half,         // half period, samples
  output var  logic [11:0] audio_sample, // sample
  output var  logic        audio_valid   // strobe
);
  logic [3:0] gap;
  logic [5:0] step;
  logic       up;
  // triangle between -pk and +pk, so the dc remover sees no steps
  function automatic logic [11:0] wave(input logic rise, input logic [5:0] pos, input logic [10:0] pk,
                                       input logic [5:0] span);
    int inc;
    int v;
    inc = (2 * int'(pk)) / int'(span);
    v = rise ? int'(pos) * inc - int'(pk) : int'(pk) - int'(pos) * inc;
    return v[11:0];
  endfunction
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 4'h0;
      step <= 6'h00;
      up <= 1'h1;
      audio_valid <= 1'h0;
      audio_sample <= 12'h000;
    end else begin
      audio_valid <= 1'h0;
      gap <= gap + 4'h1;
      if (!en) begin
        audio_sample <= ~audio_sample; // silent source inverts the last sample every cycle, with no strobe
      end else if (gap == 4'hF) begin
        audio_valid <= 1'h1;
        audio_sample <= wave(up, step, amp, half);
        if (step == half - 6'h01) begin
          step <= 6'h00;
          up <= ~up;
        end else begin
          step <= step + 6'h01;
        end
      end
    end
  end
endmodule // asl_audio_source
`default_nettype wire

// >>> dv/asl_audio_follow_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "asl_defines.vh"
module asl_audio_follow_monitor (
  input wire logic        clk_sys,      // clock
  input wire logic        rst_n,        // reset
  input wire logic [7:0]  reg_addr,     // offset
  input wire logic [7:0]  reg_wdata,    // wdata
  input wire logic        reg_wr,       // write
  input wire logic        reg_rd,       // read
  input wire logic [7:0]  reg_rdata,    // rdata
  input wire logic [11:0] audio_sample, // sample
  input wire logic        audio_valid,  // strobe
  input wire logic [7:0]  led_red,      // red
  input wire logic [7:0]  led_green,    // green
  input wire logic [7:0]  led_blue,     // blue
  input wire logic [2:0]  gain_now,     // gain
  input wire logic        follow_active // running
);
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // shadow copies of the two config registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_a <= `ASL_CFG_A_RESET;
      cfg_b <= `ASL_CFG_B_RESET;
    end else if (reg_wr && reg_addr == `ASL_CFG_A_ADDR) begin
      cfg_a <= reg_wdata;
    end else if (reg_wr && reg_addr == `ASL_CFG_B_ADDR) begin
      cfg_b <= reg_wdata & `ASL_CFG_B_MASK;
    end
  end
  a_cfg_a_readback: assert property (reg_rd && reg_addr == 8'h2A |=> reg_rdata == $past(cfg_a))
    else $error("config a readback");
  a_cfg_b_readback: assert property (reg_rd && reg_addr == 8'h2B |=> reg_rdata == $past(cfg_b))
    else $error("config b readback");
  a_unmapped_read_zero: assert property (reg_rd && reg_addr[7:1] != 7'h15 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_manual_gain_used: assert property (!cfg_a[3] && $stable(cfg_a) |-> gain_now == cfg_a[7:5])
    else $error("manual gain");
  a_follow_gate: assert property ($stable(cfg_a) |-> follow_active == (cfg_a[2] && cfg_a[1:0] == 2'h0))
    else $error("follow gate");
  a_idle_leds_dark: assert property (!follow_active && !$past(follow_active) |-> {led_red, led_green, led_blue} == 24'h0)
    else $error("leds lit while idle");
  a_leds_hold_between: assert property (follow_active && $past(follow_active) && $changed(led_red) |-> $past(audio_valid, 3))
    else $error("led change without sample");
  a_auto_start_gain: assert property ($rose(follow_active) && cfg_a[3] |-> ##[0:1] gain_now == cfg_a[7:5])
    else $error("auto gain start");
  cover property ($rose(follow_active) && cfg_a[4]);
  cover property (follow_active && led_green != 8'h00);
  cover property ($rose(follow_active) && cfg_a[3]);
endmodule // asl_audio_follow_monitor
bind asl_audio_follow asl_audio_follow_monitor i_asl_audio_follow_monitor (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .audio_sample(audio_sample), .audio_valid(audio_valid), .led_red(led_red), .led_green(led_green),
  .led_blue(led_blue), .gain_now(gain_now), .follow_active(follow_active));
`default_nettype wire

// >>> dv/tb_audio_sync_light_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_audio_sync_light_control;
  logic        clk_sys, rst_n, reg_wr, reg_rd, audio_valid, src_en, follow_active;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, led_red, led_green, led_blue;
  logic [11:0] audio_sample;
  logic [10:0] amp;
  logic [5:0]  half;
  logic [2:0]  gain_now;
  int          n_mismatch, comparisons;
  always #4 clk_sys = ~clk_sys;
  asl_audio_follow i_asl_audio_follow (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .audio_sample(audio_sample),
    .audio_valid(audio_valid), .led_red(led_red), .led_green(led_green), .led_blue(led_blue),
    .gain_now(gain_now), .follow_active(follow_active));
  asl_audio_source i_asl_audio_source (.clk_sys(clk_sys), .rst_n(rst_n), .en(src_en), .amp(amp), .half(half),
    .audio_sample(audio_sample), .audio_valid(audio_valid));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  task run(input logic [7:0] a, input logic [7:0] b, input logic [5:0] h);
    wr(8'h2A, 8'h03);
    wr(8'h2B, b);
    wr(8'h2A, a);
    half <= h;
    src_en <= 1'h1;
    idle(3000);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd_chk(8'h2A, 8'h03);
    rd_chk(8'h2B, 8'h00);
    check({5'h00, gain_now}, 8'h00);
    check({7'h00, follow_active}, 8'h00);
    $display("reset test done");
  endtask
  task t_gain;
    for (int g = 0; g < 8; g++) begin
      wr(8'h2A, {g[2:0], g[0], 4'h3});
      rd_chk(8'h2A, {g[2:0], g[0], 4'h3});
      check({5'h00, gain_now}, {5'h00, g[2:0]});
    end
    $display("gain test done");
  endtask
  task t_regb;
    wr(8'h2B, 8'hFF);
    rd_chk(8'h2B, 8'h1F);
    wr(8'h2C, 8'h5A);
    rd_chk(8'h2C, 8'h00);
    $display("register b test done");
  endtask
  task t_source;
    for (int s = 0; s < 4; s++) begin
      wr(8'h2A, {6'h01, s[1:0]});
      idle(2);
      check({7'h00, follow_active}, {7'h00, s == 0});
    end
    $display("source test done");
  endtask
  task t_amp;
    for (int m = 0; m < 3; m++) begin
      run(8'h04, {4'h0, m[1:0], 2'h0}, 6'h08);
      check({7'h00, (led_red | led_green | led_blue) != 8'h00}, 8'h01);
    end
    wr(8'h2A, 8'h07);
    idle(2);
    check(led_red | led_green | led_blue, 8'h00);
    $display("amplitude test done");
  endtask
  task t_freq;
    run(8'h94, 8'h11, 6'h20);
    check({7'h00, led_red > led_green}, 8'h01);
    run(8'h14, 8'h17, 6'h01);
    check({7'h00, led_green > led_red}, 8'h01);
    $display("frequency test done");
  endtask
  task t_speed;
    logic [7:0] fast_lvl, slow_lvl, slow_start;
    run(8'h04, 8'h00, 6'h08);
    amp <= 11'h000;
    idle(400);
    fast_lvl = led_red;
    amp <= 11'h7FF;
    run(8'h04, 8'h03, 6'h08);
    slow_start = led_red;
    amp <= 11'h000;
    idle(400);
    slow_lvl = led_red;
    amp <= 11'h7FF;
    check({7'h00, slow_lvl > fast_lvl}, 8'h01);
    check({7'h00, slow_lvl >= slow_start - (slow_start >> 2)}, 8'h01);
    $display("speed test done");
  endtask
  task t_auto;
    wr(8'h2A, 8'h03);
    amp <= 11'h040;
    wr(8'h2A, 8'hAC);
    idle(2);
    check({5'h00, gain_now}, 8'h05);
    idle(4500);
    check({5'h00, gain_now}, 8'h06);
    amp <= 11'h7FF;
    rst_n <= 1'h0;
    idle(2);
    rst_n <= 1'h1;
    $display("auto level test done");
    t_reset;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'h0;
    {rst_n, reg_wr, reg_rd, src_en} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    amp = 11'h7FF;
    half = 6'h08;
    n_mismatch = 0;
    comparisons = 0;
    idle(3);
    rst_n <= 1'h1;
    t_reset;
    t_gain;
    t_regb;
    t_source;
    t_amp;
    t_freq;
    t_speed;
    t_auto;
    stop_test;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    stop_test;
  end
endmodule // tb_audio_sync_light_control
`default_nettype wire
